//--- rtl/ipc_bank.sv
// Summary of operation
// - flag registers read back posted flags
// - zero write, posting off, clears flag
// - clearing an empty flag changes nothing
// - one write, posting on, posts flag
// - one write, posting off, no effect
// - zero write, posting on, no effect
// - mask zero masks, one unmasks source
// - masked source still sets posted flag
// - only unmasked posted flags become pending
// - lower mask: ep3..ep0, sof, reset, timers
// - upper mask: wake bit5, ep8..ep4 below
// - lower flags: ep3..ep0, sof, reset, timers
// - upper flags: wake bit5, ep8..ep4 below
// - posting enable is bit0 of own register
`timescale 1ns/1ns
`default_nettype none
module ipc_bank (
  input  wire logic                            core_clk_i,
  input  wire logic                            arst_n_i,
  input  wire ipc_pkg::ipc_bus_req_t           bus_i,
  output var  logic [ipc_pkg::DATA_W-1:0]      rd_data_o,
  input  wire logic [ipc_pkg::NUM_SRC-1:0]     src_evt_i,
  output var  logic [ipc_pkg::NUM_SRC-1:0]     posted_o,
  output var  logic [ipc_pkg::NUM_SRC-1:0]     pending_o,
  output var  logic                            soft_post_enable_o
);

  localparam int LO = ipc_pkg::NUM_LO;
  localparam int HI = ipc_pkg::NUM_HI;
  localparam int NS = ipc_pkg::NUM_SRC;

  logic [LO-1:0]             source_mask_lower_r;
  logic [HI-1:0]             source_mask_upper_r;
  logic                      soft_post_enable_r;
  logic [ipc_pkg::DATA_W-1:0] rd_data_r;
  logic [ipc_pkg::DATA_W-1:0] rd_data_nxt;
  logic [NS-1:0]             flags_q;
  logic [NS-1:0]             mask_q;
  logic [NS-1:0]             sw_post;
  logic [NS-1:0]             sw_clr;
  logic [NS-1:0]             wr_bits;
  logic [NS-1:0]             wr_sel;

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  wire hit_flags_lo = bus_i.addr == ipc_pkg::OFF_FLAGS_LO;
  wire hit_flags_hi = bus_i.addr == ipc_pkg::OFF_FLAGS_HI;
  wire hit_mask_lo  = bus_i.addr == ipc_pkg::OFF_MASK_LO;
  wire hit_mask_hi  = bus_i.addr == ipc_pkg::OFF_MASK_HI;
  wire hit_soft_en  = bus_i.addr == ipc_pkg::OFF_SOFT_EN;

  wire wr_flags_lo = bus_i.wr & hit_flags_lo;
  wire wr_flags_hi = bus_i.wr & hit_flags_hi;
  wire wr_mask_lo  = bus_i.wr & hit_mask_lo;
  wire wr_mask_hi  = bus_i.wr & hit_mask_hi;
  wire wr_soft_en  = bus_i.wr & hit_soft_en;

  // ---------------------------------------------------------------
  // write effects on posted flags
  // ---------------------------------------------------------------
  // reserved bits 7:6 of the upper flag register are dropped here,
  // so a careless nonzero write there cannot reach any flag
  assign wr_bits = {bus_i.wdata[HI-1:0], bus_i.wdata};
  assign wr_sel  = {{HI{wr_flags_hi}}, {LO{wr_flags_lo}}};

  // posting enabled: ones post, zeros do nothing
  assign sw_post = wr_sel & wr_bits & {NS{soft_post_enable_r}};
  // posting disabled: zeros clear, ones do nothing
  assign sw_clr  = wr_sel & ~wr_bits
                 & {NS{~soft_post_enable_r}};

  assign mask_q = {source_mask_upper_r, source_mask_lower_r};

  // ---------------------------------------------------------------
  // per-source flag cells
  // ---------------------------------------------------------------
  for (genvar i = 0; i < NS; i++) begin : g_src
    ipc_flag_cell u_cell (
      .core_clk_i (core_clk_i),
      .arst_n_i   (arst_n_i),
      .evt_i      (src_evt_i[i]),
      .sw_post_i  (sw_post[i]),
      .sw_clr_i   (sw_clr[i]),
      .unmask_i   (mask_q[i]),
      .posted_o   (flags_q[i]),
      .pending_o  (pending_o[i])
    );
  end

  assign posted_o = flags_q;

  // ---------------------------------------------------------------
  // control registers
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      source_mask_lower_r <= ipc_pkg::RST_MASK_LO;
      source_mask_upper_r <= ipc_pkg::RST_MASK_HI;
      soft_post_enable_r  <= ipc_pkg::RST_SOFT_EN;
    end else begin
      if (wr_mask_lo) begin
        source_mask_lower_r <= bus_i.wdata;
      end
      if (wr_mask_hi) begin
        source_mask_upper_r <= bus_i.wdata[HI-1:0];
      end
      if (wr_soft_en) begin
        soft_post_enable_r <= bus_i.wdata[ipc_pkg::SOFT_EN_BIT];
      end
    end
  end

  assign soft_post_enable_o = soft_post_enable_r;

  // ---------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------
  // data stands only in the cycle after the strobe; unmapped reads
  // and reserved bits return zero
  wire [ipc_pkg::DATA_W-1:0] rd_flags_lo = flags_q[LO-1:0];
  wire [ipc_pkg::DATA_W-1:0] rd_flags_hi = {2'h0, flags_q[NS-1:LO]};
  wire [ipc_pkg::DATA_W-1:0] rd_mask_hi  = {2'h0, source_mask_upper_r};
  wire [ipc_pkg::DATA_W-1:0] rd_soft_en  = {7'h00, soft_post_enable_r};

  assign rd_data_nxt =
    !bus_i.rd    ? ipc_pkg::RD_ZERO :
    hit_flags_lo ? rd_flags_lo :
    hit_flags_hi ? rd_flags_hi :
    hit_mask_lo  ? source_mask_lower_r :
    hit_mask_hi  ? rd_mask_hi :
    hit_soft_en  ? rd_soft_en :
                   ipc_pkg::RD_ZERO;

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rd_data_r <= ipc_pkg::RD_ZERO;
    end else begin
      rd_data_r <= rd_data_nxt;
    end
  end

  assign rd_data_o = rd_data_r;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!arst_n_i);

  wire no_evt = src_evt_i == '0;

  AST_RD_FLAGS_LO: assert property (
    bus_i.rd && hit_flags_lo |=> rd_data_o == $past(flags_q[LO-1:0])
  ) else $error("lower flag read does not show posted flags");

  AST_RD_FLAGS_HI: assert property (
    bus_i.rd && hit_flags_hi
    |=> rd_data_o == {2'h0, $past(flags_q[NS-1:LO])}
  ) else $error("upper flag read wrong or reserved bits set");

  AST_CLR_LO: assert property (
    wr_flags_lo && !soft_post_enable_r && no_evt
    |=> flags_q[LO-1:0] == ($past(flags_q[LO-1:0]) & $past(bus_i.wdata))
  ) else $error("clearing write did not clear exactly the zero bits");

  // a clearing write may only lower flags, so an empty one stays empty
  AST_CLR_EMPTY: assert property (
    wr_flags_hi && !soft_post_enable_r && no_evt
    |=> (flags_q & ~$past(flags_q)) == '0
  ) else $error("clearing write raised a flag");

  AST_POST_LO: assert property (
    wr_flags_lo && soft_post_enable_r
    |=> (flags_q[LO-1:0] & $past(bus_i.wdata)) == $past(bus_i.wdata)
  ) else $error("software post did not set flags");

  AST_ONE_NO_CLR: assert property (
    wr_flags_hi && !soft_post_enable_r && no_evt
    |=> (flags_q[NS-1:LO] & $past(bus_i.wdata[HI-1:0]))
        == ($past(flags_q[NS-1:LO]) & $past(bus_i.wdata[HI-1:0]))
  ) else $error("one written with posting off changed a flag");

  AST_ZERO_NO_EFFECT: assert property (
    wr_flags_lo && soft_post_enable_r && no_evt
    |=> flags_q[LO-1:0]
        == ($past(flags_q[LO-1:0]) | $past(bus_i.wdata))
  ) else $error("zero written with posting on changed a flag");

  AST_PEND_MASK: assert property (
    ##1 pending_o == $past(flags_q & mask_q)
  ) else $error("pending does not follow posted and unmasked");

  AST_MASKED_POSTS: assert property (
    (src_evt_i & ~mask_q) != '0
    |=> (flags_q & $past(src_evt_i)) == $past(src_evt_i)
        ##1 (pending_o & $past(src_evt_i, 2) & ~$past(mask_q)) == '0
  ) else $error("masked source failed to post or became pending");

  AST_SET_WINS: assert property (
    (src_evt_i & sw_clr) != '0
    |=> (flags_q & $past(src_evt_i & sw_clr)) == $past(src_evt_i & sw_clr)
  ) else $error("event lost against clearing write");

  AST_MASK_MAP: assert property (
    wr_mask_lo |=> mask_q[LO-1:0] == $past(bus_i.wdata)
  ) else $error("lower mask did not store written value");

  AST_MASK_HI: assert property (
    wr_mask_hi |=> mask_q[NS-1:LO] == $past(bus_i.wdata[HI-1:0])
  ) else $error("upper mask map wrong");

  AST_MASK_SENSE: assert property (
    !mask_q[ipc_pkg::SRC_TIMER1] && flags_q[ipc_pkg::SRC_TIMER1]
    ##1 !mask_q[ipc_pkg::SRC_TIMER1] |-> !pending_o[ipc_pkg::SRC_TIMER1]
  ) else $error("mask zero did not mask");

  AST_SOFT_EN: assert property (
    wr_soft_en
    |=> soft_post_enable_o == $past(bus_i.wdata[ipc_pkg::SOFT_EN_BIT])
  ) else $error("posting enable not at bit 0");

  AST_FLAG_MAP: assert property (
    src_evt_i[ipc_pkg::SRC_EP0] ##1 !wr_flags_lo
    ##1 bus_i.rd && hit_flags_lo |=> rd_data_o[ipc_pkg::SRC_EP0]
  ) else $error("endpoint 0 flag not at bit 4");

  // ---------------------------------------------------------------
  // read path checks
  // ---------------------------------------------------------------
  AST_RD_IDLE: assert property (
    !bus_i.rd |=> rd_data_o == ipc_pkg::RD_ZERO
  ) else $error("read data not zero outside a read");

  AST_RD_UNMAPPED: assert property (
    bus_i.rd && !(hit_flags_lo || hit_flags_hi || hit_mask_lo
                  || hit_mask_hi || hit_soft_en)
    |=> rd_data_o == ipc_pkg::RD_ZERO
  ) else $error("unmapped read returned nonzero data");

  AST_RD_MASK_LO: assert property (
    bus_i.rd && hit_mask_lo |=> rd_data_o == $past(mask_q[LO-1:0])
  ) else $error("lower mask read back wrong");

  AST_RD_MASK_HI: assert property (
    bus_i.rd && hit_mask_hi
    |=> rd_data_o == {2'h0, $past(mask_q[NS-1:LO])}
  ) else $error("upper mask read back wrong");

  AST_RD_SOFT_EN: assert property (
    bus_i.rd && hit_soft_en
    |=> rd_data_o == {7'h00, $past(soft_post_enable_o)}
  ) else $error("posting enable read back wrong");

  // ---------------------------------------------------------------
  // upper flag write checks and the lower posting-off one-write check
  // ---------------------------------------------------------------
  // events are excluded where they could legally raise a bit that the
  // write itself must leave alone
  AST_CLR_HI: assert property (
    wr_flags_hi && !soft_post_enable_r && no_evt
    |=> flags_q[NS-1:LO]
        == ($past(flags_q[NS-1:LO]) & $past(bus_i.wdata[HI-1:0]))
  ) else $error("upper clearing write did not clear the zero bits");

  AST_POST_HI: assert property (
    wr_flags_hi && soft_post_enable_r
    |=> (flags_q[NS-1:LO] & $past(bus_i.wdata[HI-1:0]))
        == $past(bus_i.wdata[HI-1:0])
  ) else $error("software post did not set upper flags");

  AST_ONE_NO_CLR_LO: assert property (
    wr_flags_lo && !soft_post_enable_r && no_evt
    |=> (flags_q[LO-1:0] & $past(bus_i.wdata))
        == ($past(flags_q[LO-1:0]) & $past(bus_i.wdata))
  ) else $error("one written with posting off changed a lower flag");

  AST_ZERO_NO_EFFECT_HI: assert property (
    wr_flags_hi && soft_post_enable_r && no_evt
    |=> flags_q[NS-1:LO]
        == ($past(flags_q[NS-1:LO]) | $past(bus_i.wdata[HI-1:0]))
  ) else $error("zero written with posting on changed an upper flag");

  // ---------------------------------------------------------------
  // state holding, event posting and pending checks
  // ---------------------------------------------------------------
  AST_FLAG_HOLD: assert property (
    !wr_flags_lo && !wr_flags_hi && no_evt |=> $stable(flags_q)
  ) else $error("posted flag changed with no write or event");

  AST_EVT_POSTS: assert property (
    src_evt_i != '0
    |=> (flags_q & $past(src_evt_i)) == $past(src_evt_i)
  ) else $error("source event did not post its flag");

  AST_MASK_LO_HOLD: assert property (
    !wr_mask_lo |=> $stable(mask_q[LO-1:0])
  ) else $error("lower mask changed without a write");

  AST_MASK_HI_HOLD: assert property (
    !wr_mask_hi |=> $stable(mask_q[NS-1:LO])
  ) else $error("upper mask changed without a write");

  AST_SOFT_HOLD: assert property (
    !wr_soft_en |=> $stable(soft_post_enable_o)
  ) else $error("posting enable changed without a write");

  AST_PEND_UNMASKED: assert property (
    mask_q[ipc_pkg::SRC_WAKE] && flags_q[ipc_pkg::SRC_WAKE]
    |=> pending_o[ipc_pkg::SRC_WAKE]
  ) else $error("unmasked posted wake did not become pending");

  COV_CLEAR: cover property (
    wr_flags_lo && !soft_post_enable_r && flags_q[ipc_pkg::SRC_SOF]
  );
  COV_POST: cover property (
    wr_flags_hi && soft_post_enable_r && bus_i.wdata[5]
  );
  COV_SET_WINS: cover property ((src_evt_i & sw_clr) != '0);
  COV_WAKE_PEND: cover property (pending_o[ipc_pkg::SRC_WAKE]);
  COV_MASKED_POST: cover property ((src_evt_i & ~mask_q) != '0);

endmodule
`default_nettype wire

//--- common/ipc_pkg.sv
`default_nettype none
package ipc_pkg;

  // ---------------------------------------------------------------
  // bus and bank geometry
  // ---------------------------------------------------------------
  localparam int ADDR_W  = 8;
  localparam int DATA_W  = 8;
  localparam int NUM_LO  = 8;
  localparam int NUM_HI  = 6;
  localparam int NUM_SRC = NUM_LO + NUM_HI;

  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFF_FLAGS_LO = 8'hdb;
  localparam logic [ADDR_W-1:0] OFF_FLAGS_HI = 8'hdc;
  localparam logic [ADDR_W-1:0] OFF_MASK_HI  = 8'hde;
  localparam logic [ADDR_W-1:0] OFF_MASK_LO  = 8'hdf;
  localparam logic [ADDR_W-1:0] OFF_SOFT_EN  = 8'he1;

  // ---------------------------------------------------------------
  // fields and reset values
  // ---------------------------------------------------------------
  localparam int SOFT_EN_BIT = 0;
  localparam logic [NUM_LO-1:0] RST_MASK_LO = 8'h00;
  localparam logic [NUM_HI-1:0] RST_MASK_HI = 6'h00;
  localparam logic              RST_SOFT_EN = 1'b0;
  localparam logic              RST_FLAG    = 1'b0;
  localparam logic [DATA_W-1:0] RD_ZERO     = 8'h00;

  // ---------------------------------------------------------------
  // source positions in the flat event vector
  // ---------------------------------------------------------------
  localparam int SRC_TIMER1  = 0;
  localparam int SRC_TIMER2  = 1;
  localparam int SRC_BUS_RST = 2;
  localparam int SRC_SOF     = 3;
  localparam int SRC_EP0     = 4;
  localparam int SRC_EP4     = 8;
  localparam int SRC_WAKE    = 13;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } ipc_bus_req_t;

endpackage
`default_nettype wire

//--- rtl/ipc_flag_cell.sv
`timescale 1ns/1ns
`default_nettype none
module ipc_flag_cell (
  input  wire logic core_clk_i,
  input  wire logic arst_n_i,
  input  wire logic evt_i,
  input  wire logic sw_post_i,
  input  wire logic sw_clr_i,
  input  wire logic unmask_i,
  output var  logic posted_o,
  output var  logic pending_o
);

  logic flag_r;
  logic flag_nxt;
  logic pending_r;

  // ---------------------------------------------------------------
  // posted flag
  // ---------------------------------------------------------------
  // a source event outranks a clearing write in the same cycle
  assign flag_nxt = evt_i | sw_post_i | (flag_r & ~sw_clr_i);

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      flag_r    <= ipc_pkg::RST_FLAG;
      pending_r <= ipc_pkg::RST_FLAG;
    end else begin
      flag_r    <= flag_nxt;
      pending_r <= flag_r & unmask_i;
    end
  end

  assign posted_o  = flag_r;
  assign pending_o = pending_r;

endmodule
`default_nettype wire

//--- tb/ipc_src_model.sv
`timescale 1ns/1ns
`default_nettype none
// ---------------------------------------------------------------
// peripheral interrupt sources
// ---------------------------------------------------------------
module ipc_src_model (
  input  wire logic        arst_n_i,
  input  wire logic [13:0] fire_i,
  output var  logic [13:0] evt_o
);
  // sources sit in the bank's clock domain, so no sync is needed;
  // they stay quiet while the system is held in reset
  always_comb begin
    evt_o = arst_n_i ? fire_i : 14'h0000;
  end
endmodule
`default_nettype wire

//--- tb/testbench.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin \
  err_total++; $display("Error %s expected %h seen %h", nm, ex, got); \
  end end
module testbench;
  // ---------------------------------------------------------------
  // signals and reference state
  // ---------------------------------------------------------------
  logic                  core_clk_i = 1'b0;
  logic                  arst_n_i   = 1'b0;
  ipc_pkg::ipc_bus_req_t bus        = '0;
  logic [13:0]           fire       = 14'h0000;
  logic [13:0]           evt;
  logic [7:0]            rd_data;
  logic [13:0]           posted;
  logic [13:0]           pending;
  logic                  soft_en;
  logic [13:0]           m_flag     = 14'h0000;
  logic [13:0]           m_mask     = 14'h0000;
  logic                  m_en       = 1'b0;
  logic [7:0]            a;
  logic [7:0]            d;
  logic [13:0]           e;
  int                    k;
  int                    err_total  = 0;
  int                    compares   = 0;
  int                    cycles     = 0;
  int                    seed       = 32'h5682f5a8;
  logic [7:0]            addr_tbl [6] = '{ipc_pkg::OFF_FLAGS_LO,
    ipc_pkg::OFF_FLAGS_HI, ipc_pkg::OFF_MASK_HI, ipc_pkg::OFF_MASK_LO,
    ipc_pkg::OFF_SOFT_EN, 8'h00};

  always #2 core_clk_i = ~core_clk_i;

  ipc_bank i_ipc_bank (
    .core_clk_i         (core_clk_i),
    .arst_n_i           (arst_n_i),
    .bus_i              (bus),
    .rd_data_o          (rd_data),
    .src_evt_i          (evt),
    .posted_o           (posted),
    .pending_o          (pending),
    .soft_post_enable_o (soft_en)
  );

  ipc_src_model i_ipc_src_model (
    .arst_n_i (arst_n_i),
    .fire_i   (fire),
    .evt_o    (evt)
  );

  // ---------------------------------------------------------------
  // reference model
  // ---------------------------------------------------------------
  function automatic logic [7:0] exp_rd(input logic [7:0] ad);
    case (ad)
      ipc_pkg::OFF_FLAGS_LO: exp_rd = m_flag[7:0];
      ipc_pkg::OFF_FLAGS_HI: exp_rd = {2'b00, m_flag[13:8]};
      ipc_pkg::OFF_MASK_HI:  exp_rd = {2'b00, m_mask[13:8]};
      ipc_pkg::OFF_MASK_LO:  exp_rd = m_mask[7:0];
      ipc_pkg::OFF_SOFT_EN:  exp_rd = {7'h00, m_en};
      default:               exp_rd = 8'h00;
    endcase
  endfunction

  task automatic model_upd(input logic w, input logic [7:0] ad,
                           input logic [7:0] dt, input logic [13:0] ev);
    logic [13:0] hit;
    logic [13:0] val;
    hit = !w ? 14'h0000 : (ad == ipc_pkg::OFF_FLAGS_LO) ? 14'h00ff :
          (ad == ipc_pkg::OFF_FLAGS_HI) ? 14'h3f00 : 14'h0000;
    val = {dt[5:0], dt};
    if (m_en) m_flag = m_flag | (hit & val);
    else m_flag = m_flag & ~(hit & ~val);
    m_flag = m_flag | ev;
    if (w && ad == ipc_pkg::OFF_MASK_LO) m_mask[7:0] = dt;
    if (w && ad == ipc_pkg::OFF_MASK_HI) m_mask[13:8] = dt[5:0];
    if (w && ad == ipc_pkg::OFF_SOFT_EN) m_en = dt[0];
  endtask

  // ---------------------------------------------------------------
  // one bus cycle plus two idle cycles, the first to see pending settle
  // ---------------------------------------------------------------
  task automatic bus_op(input logic w, input logic r, input logic [7:0] ad,
                        input logic [7:0] dt, input logic [13:0] ev);
    logic [7:0] x;
    x = exp_rd(ad);
    bus.addr  <= ad;
    bus.wdata <= dt;
    bus.wr    <= w;
    bus.rd    <= r;
    fire      <= ev;
    @(posedge core_clk_i);
    bus.wr <= 1'b0;
    bus.rd <= 1'b0;
    fire   <= 14'h0000;
    model_upd(w, ad, dt, ev);
    @(negedge core_clk_i);
    if (r) `CHK("rd_data", x, rd_data);
    `CHK("posted", m_flag, posted);
    `CHK("soft_en", m_en, soft_en);
    @(posedge core_clk_i);
    @(negedge core_clk_i);
    `CHK("pending", m_flag & m_mask, pending);
    `CHK("rd_idle", 8'h00, rd_data);
    @(posedge core_clk_i);
  endtask

  task automatic finish_test();
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // hang guard: 600 operations take about 1800 cycles
  // ---------------------------------------------------------------
  always @(posedge core_clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      err_total++;
      finish_test();
    end
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (5) @(posedge core_clk_i);
    arst_n_i <= 1'b1;
    @(posedge core_clk_i);
    for (int i = 0; i < 6; i++) begin
      bus_op(1'b0, 1'b1, addr_tbl[i], 8'h00, 14'h0000);
    end
    // mixed writes, reads and source events, some on the same edge
    for (int i = 0; i < 600; i++) begin
      a = addr_tbl[$unsigned($random(seed)) % 6];
      d = $random(seed);
      if (a == ipc_pkg::OFF_FLAGS_HI || a == ipc_pkg::OFF_MASK_HI) begin
        d[7:6] = 2'b00;
      end
      if (a == ipc_pkg::OFF_SOFT_EN) begin
        d[7:1] = 7'h00;
      end
      k = $unsigned($random(seed)) % 4;
      e = (k == 0 || k == 3) ? 14'($random(seed) & $random(seed)) : '0;
      bus_op(k < 2, k == 2, a, d, e);
    end
    finish_test();
  end
endmodule
`default_nettype wire
